// file: rtl/frs_top.sv
// Frequency reference source selection, multi-step and pulse-train scaling
// Behaviour
// - Source setting 0..4 picks reference, default 1
// - Pulse function routes value: freq, PID fb, target
// - Full-scale 1000..32000 equals 100%, default 1440
// - Analog source uses primary or secondary terminal
// - Bit0 contact off primary, on secondary
// - Secondary function 0 adds secondary to primary
// - Swap makes secondary master, primary auxiliary
// - Source 4 uses pulse frequency; function 0
// - Seventeen speeds: sixteen steps plus jog
// - Jog contact overrides multi-step selection
// - Step contacts binary-select stored references
//
// Decided for this implementation: the register offsets and the plain strobed port.
`timescale 1ns/100ps
module frs_top #(
    parameter int unsigned GATE_CYCLES = frs_pkg::GATE_CYCLES_DEF
) (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Register port
    input wire frs_pkg::frs_req_t req_i,
    output logic [31:0] rd_data_o,
    // Reference sources
    input wire logic [15:0] analog_in_primary_i,
    input wire logic [15:0] analog_in_secondary_i,
    input wire logic [15:0] option_ref_i,
    // Contact and pulse pins
    input wire logic [3:0] step_select_i,
    input wire logic jog_select_input_i,
    input wire logic pulse_train_input_pin_i,
    // Results
    output logic [15:0] freq_ref_o,
    output logic [15:0] pid_feedback_o,
    output logic [15:0] pid_target_o,
    output logic jog_active_o
);
    import frs_pkg::*;

    typedef enum logic {DIV_IDLE, DIV_RUN} frs_div_t;

    function automatic logic [15:0] frs_sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        frs_sat_add = (s > {1'b0, PCT_FULL}) ? PCT_FULL : s[15:0];
    endfunction : frs_sat_add

    function automatic logic frs_is_step(input logic [7:0] a);
        frs_is_step = (a >= ADDR_STEP_BASE) && (a <= ADDR_STEP_LAST) && (a[1:0] == 2'h0);
    endfunction : frs_is_step

    frs_cfg_t cfg_q;
    logic [15:0] fscale_q;
    logic [15:0] keypad_q;
    logic [15:0] serial_q;
    logic [15:0] steps_q [0:JOG_IDX];
    logic [NUM_PINS-1:0] sync1_q;
    logic [NUM_PINS-1:0] sync2_q;
    logic pulse_d1_q;
    logic [GATE_W-1:0] gate_cnt_q;
    logic gate_tick;
    logic [15:0] edge_cnt_q;
    logic [15:0] pulse_hz_q;
    frs_div_t div_st_q;
    logic [4:0] div_cnt_q;
    logic [NUM_W-1:0] num_q;
    logic [NUM_W-1:0] quo_q;
    logic [16:0] rem_q;
    logic [16:0] rem_sh;
    logic [15:0] pct_q;
    logic [15:0] freq_ref_q;
    logic [15:0] pid_fb_q;
    logic [15:0] pid_tgt_q;
    logic jog_q;
    logic [31:0] rd_q;
    logic [3:0] step_idx;
    logic jog_s;
    logic aux_mode;
    logic [15:0] master_ref;
    logic [15:0] aux_ref;
    logic [15:0] src_ref;
    logic [15:0] sel_d;
    logic [15:0] step_pick;
    logic [4:0] step_word;
    logic cfg_err;

    // Contact and pulse pins are asynchronous to the control clock
    generate
        for (genvar i = 0; i < NUM_PINS; i++) begin : g_sync
            always_ff @(posedge mclk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    sync1_q[i] <= 1'b0;
                    sync2_q[i] <= 1'b0;
                end else begin
                    sync1_q[i] <= (i < 4) ? step_select_i[i % 4] :
                                  (i == PIN_JOG) ? jog_select_input_i : pulse_train_input_pin_i;
                    sync2_q[i] <= sync1_q[i];
                end
            end
        end
    endgenerate

    assign step_idx = sync2_q[3:0];
    assign jog_s = sync2_q[PIN_JOG];
    assign step_word = 5'((req_i.addr - ADDR_STEP_BASE) >> 2);

    // Register writes; out-of-range settings are ignored, not clipped
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_q <= '{a2fn: A2FN_ADD, swap: 1'b0, pfn: PFN_FREQ, src: SRC_RST};
            fscale_q <= FS_RST;
            keypad_q <= 16'h0000;
            serial_q <= 16'h0000;
        end else if (req_i.wr) begin
            if (req_i.addr == ADDR_CTRL) begin
                if (req_i.wdata[CTRL_SRC_LSB +: 3] <= SRC_PULSE) begin
                    cfg_q.src <= req_i.wdata[CTRL_SRC_LSB +: 3];
                end
                if (req_i.wdata[CTRL_PFN_LSB +: 2] <= PFN_PID_TGT) begin
                    cfg_q.pfn <= req_i.wdata[CTRL_PFN_LSB +: 2];
                end
                cfg_q.swap <= req_i.wdata[CTRL_SWAP_BIT];
                cfg_q.a2fn <= req_i.wdata[CTRL_A2FN_LSB +: 5];
            end
            if (req_i.addr == ADDR_FSCALE && req_i.wdata[15:0] >= FS_MIN &&
                req_i.wdata[15:0] <= FS_MAX) begin
                fscale_q <= req_i.wdata[15:0];
            end
            if (req_i.addr == ADDR_KEYPAD) begin
                keypad_q <= req_i.wdata[15:0];
            end
            if (req_i.addr == ADDR_SERIAL) begin
                serial_q <= req_i.wdata[15:0];
            end
        end
    end

    // Sixteen step references and the jog reference
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int k = 0; k <= JOG_IDX; k++) begin
                steps_q[k] <= 16'h0000;
            end
        end else if (req_i.wr && frs_is_step(req_i.addr)) begin
            steps_q[step_word] <= req_i.wdata[15:0];
        end
    end

    // Gate window: edge count over one gate period reads directly in Hz
    assign gate_tick = (gate_cnt_q == GATE_W'(GATE_CYCLES - 1));

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gate_cnt_q <= '0;
            edge_cnt_q <= 16'h0000;
            pulse_hz_q <= 16'h0000;
            pulse_d1_q <= 1'b0;
        end else begin
            pulse_d1_q <= sync2_q[PIN_PULSE];
            gate_cnt_q <= gate_tick ? '0 : gate_cnt_q + 1'b1;
            if (gate_tick) begin
                pulse_hz_q <= edge_cnt_q;
                // An edge in the tick cycle opens the next window, so none is lost
                edge_cnt_q <= (sync2_q[PIN_PULSE] && !pulse_d1_q) ? 16'h0001 : 16'h0000;
            end else if (sync2_q[PIN_PULSE] && !pulse_d1_q && edge_cnt_q != 16'hFFFF) begin
                edge_cnt_q <= edge_cnt_q + 16'h0001;
            end
        end
    end

    // Restoring divider, one quotient bit per cycle; a gate tick during a run starts no division
    assign rem_sh = {rem_q[15:0], num_q[NUM_W-1]};

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            div_st_q <= DIV_IDLE;
            div_cnt_q <= 5'h00;
            num_q <= '0;
            quo_q <= '0;
            rem_q <= 17'h0_0000;
            pct_q <= 16'h0000;
        end else begin
            unique case (div_st_q)
                DIV_IDLE: begin
                    if (gate_tick) begin
                        num_q <= NUM_W'(edge_cnt_q) * NUM_W'(PCT_FULL);
                        quo_q <= '0;
                        rem_q <= 17'h0_0000;
                        div_cnt_q <= 5'h00;
                        div_st_q <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    num_q <= {num_q[NUM_W-2:0], 1'b0};
                    if (rem_sh >= {1'b0, fscale_q}) begin
                        rem_q <= rem_sh - {1'b0, fscale_q};
                        quo_q <= {quo_q[NUM_W-2:0], 1'b1};
                    end else begin
                        rem_q <= rem_sh;
                        quo_q <= {quo_q[NUM_W-2:0], 1'b0};
                    end
                    div_cnt_q <= div_cnt_q + 5'h01;
                    if (div_cnt_q == DIV_LAST) begin
                        div_st_q <= DIV_IDLE;
                    end
                end
            endcase
            if (div_st_q == DIV_IDLE && div_cnt_q == DIV_LAST + 5'h01) begin
                pct_q <= (quo_q > NUM_W'(PCT_FULL)) ? PCT_FULL : quo_q[15:0];
                div_cnt_q <= 5'h00;
            end
        end
    end

    // Analog master/auxiliary roles
    assign master_ref = cfg_q.swap ? analog_in_secondary_i : analog_in_primary_i;
    assign aux_ref = cfg_q.swap ? analog_in_primary_i : analog_in_secondary_i;
    assign aux_mode = (cfg_q.src == SRC_ANALOG) && (cfg_q.a2fn == A2FN_AUX);
    assign cfg_err = (cfg_q.src == SRC_PULSE) && (cfg_q.pfn != PFN_FREQ);
    assign step_pick = steps_q[step_idx];

    always_comb begin
        src_ref = 16'h0000;
        unique case (cfg_q.src)
            SRC_KEYPAD: src_ref = keypad_q;
            SRC_ANALOG: begin
                if (cfg_q.a2fn == A2FN_ADD) begin
                    src_ref = frs_sat_add(analog_in_primary_i, analog_in_secondary_i);
                end else begin
                    src_ref = master_ref;
                end
            end
            SRC_SERIAL: src_ref = serial_q;
            SRC_OPTION: src_ref = option_ref_i;
            SRC_PULSE: src_ref = cfg_err ? 16'h0000 : pct_q;
            default: src_ref = 16'h0000;
        endcase
    end

    always_comb begin
        if (jog_s) begin
            sel_d = steps_q[JOG_IDX];
        end else if (step_idx == 4'h0) begin
            sel_d = src_ref;
        end else if (step_idx == 4'h1 && aux_mode) begin
            sel_d = aux_ref;
        end else begin
            sel_d = step_pick;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            freq_ref_q <= 16'h0000;
            pid_fb_q <= 16'h0000;
            pid_tgt_q <= 16'h0000;
            jog_q <= 1'b0;
        end else begin
            freq_ref_q <= sel_d;
            pid_fb_q <= (cfg_q.pfn == PFN_PID_FB) ? pct_q : 16'h0000;
            pid_tgt_q <= (cfg_q.pfn == PFN_PID_TGT) ? pct_q : 16'h0000;
            jog_q <= jog_s;
        end
    end

    // Read data stands one cycle only; unmapped addresses read zero
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_q <= 32'h0000_0000;
        end else if (req_i.rd) begin
            rd_q <= 32'h0000_0000;
            unique case (req_i.addr)
                ADDR_CTRL: begin
                    rd_q[CTRL_SRC_LSB +: 3] <= cfg_q.src;
                    rd_q[CTRL_PFN_LSB +: 2] <= cfg_q.pfn;
                    rd_q[CTRL_SWAP_BIT] <= cfg_q.swap;
                    rd_q[CTRL_A2FN_LSB +: 5] <= cfg_q.a2fn;
                end
                ADDR_FSCALE: rd_q[15:0] <= fscale_q;
                ADDR_KEYPAD: rd_q[15:0] <= keypad_q;
                ADDR_SERIAL: rd_q[15:0] <= serial_q;
                ADDR_REF_OUT: rd_q[15:0] <= freq_ref_q;
                ADDR_PULSE_HZ: rd_q[15:0] <= pulse_hz_q;
                ADDR_PULSE_PCT: rd_q[15:0] <= pct_q;
                ADDR_STATUS: begin
                    rd_q[4:0] <= jog_s ? 5'(JOG_IDX) : {1'b0, step_idx};
                    rd_q[STAT_ERR_BIT] <= cfg_err;
                    rd_q[STAT_BUSY_BIT] <= (div_st_q == DIV_RUN);
                end
                default: begin
                    if (frs_is_step(req_i.addr)) begin
                        rd_q[15:0] <= steps_q[step_word];
                    end
                end
            endcase
        end else begin
            rd_q <= 32'h0000_0000;
        end
    end

    assign rd_data_o = rd_q;
    assign freq_ref_o = freq_ref_q;
    assign pid_feedback_o = pid_fb_q;
    assign pid_target_o = pid_tgt_q;
    assign jog_active_o = jog_q;

    sequence s_div_run;
        (div_st_q == DIV_RUN) ##30 (div_st_q == DIV_IDLE);
    endsequence

    src_legal_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        cfg_q.src <= SRC_PULSE) else $error("source setting out of range");
    pfn_legal_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cfg_q.pfn <= PFN_PID_TGT) && (pid_fb_q == 16'h0000 || pid_tgt_q == 16'h0000))
        else $error("pulse function routing broken");
    fscale_range_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        fscale_q >= FS_MIN && fscale_q <= FS_MAX) else $error("full scale out of range");
    analog_prim_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cfg_q.src == SRC_ANALOG && cfg_q.a2fn != A2FN_ADD && !cfg_q.swap && !jog_s &&
         step_idx == 4'h0 && !req_i.wr) |=> freq_ref_o == $past(analog_in_primary_i))
        else $error("analog master not primary");
    aux_switch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (aux_mode && !cfg_q.swap && !jog_s && step_idx == 4'h1 && !req_i.wr)
        |=> freq_ref_o == $past(analog_in_secondary_i)) else $error("aux not secondary");
    analog_add_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cfg_q.src == SRC_ANALOG && cfg_q.a2fn == A2FN_ADD && !jog_s && step_idx == 4'h0 &&
         !req_i.wr) |=> freq_ref_o == frs_sat_add($past(analog_in_primary_i),
         $past(analog_in_secondary_i))) else $error("analog sum wrong");
    swap_aux_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (aux_mode && cfg_q.swap && !jog_s && step_idx == 4'h1 && !req_i.wr)
        |=> freq_ref_o == $past(analog_in_primary_i)) else $error("swapped aux wrong");
    pulse_src_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (cfg_q.src == SRC_PULSE && cfg_q.pfn == PFN_FREQ && !jog_s && step_idx == 4'h0 &&
         !req_i.wr) |=> freq_ref_o == $past(pct_q)) else $error("pulse source wrong");
    jog_prio_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (jog_s && !req_i.wr) |=> (freq_ref_o == steps_q[JOG_IDX]) && jog_active_o)
        else $error("jog not selected");
    step_pick_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (!jog_s && step_idx != 4'h0 && !(step_idx == 4'h1 && aux_mode) && !req_i.wr)
        |=> freq_ref_o == $past(step_pick)) else $error("step reference wrong");
    div_time_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        (gate_tick && div_st_q == DIV_IDLE) |=> s_div_run) else $error("divider timing");
    pct_sat_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        pct_q <= PCT_FULL) else $error("percent above full scale");
endmodule : frs_top

// file: rtl/frs_pkg.sv
// Constants, register map and carrier types of the frequency reference selector
package frs_pkg;
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned GATE_TIME_MS = 1000;
    localparam int unsigned GATE_CYCLES_DEF = CLK_HZ / 1000 * GATE_TIME_MS;
    localparam int GATE_W = 25;
    localparam int REF_W = 16;
    localparam int NUM_W = 30;
    localparam int NUM_STEPS = 16;
    localparam int JOG_IDX = 16;
    localparam int NUM_PINS = 6;
    localparam int PIN_JOG = 4;
    localparam int PIN_PULSE = 5;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_FSCALE = 8'h04;
    localparam logic [7:0] ADDR_KEYPAD = 8'h08;
    localparam logic [7:0] ADDR_SERIAL = 8'h0C;
    localparam logic [7:0] ADDR_REF_OUT = 8'h10;
    localparam logic [7:0] ADDR_PULSE_HZ = 8'h14;
    localparam logic [7:0] ADDR_PULSE_PCT = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_STEP_BASE = 8'h40;
    localparam logic [7:0] ADDR_STEP_LAST = 8'h80;
    localparam int CTRL_SRC_LSB = 0;
    localparam int CTRL_PFN_LSB = 4;
    localparam int CTRL_SWAP_BIT = 8;
    localparam int CTRL_A2FN_LSB = 16;
    localparam int STAT_ERR_BIT = 8;
    localparam int STAT_BUSY_BIT = 9;
    localparam logic [2:0] SRC_KEYPAD = 3'h0;
    localparam logic [2:0] SRC_ANALOG = 3'h1;
    localparam logic [2:0] SRC_SERIAL = 3'h2;
    localparam logic [2:0] SRC_OPTION = 3'h3;
    localparam logic [2:0] SRC_PULSE = 3'h4;
    localparam logic [2:0] SRC_RST = SRC_ANALOG;
    localparam logic [1:0] PFN_FREQ = 2'h0;
    localparam logic [1:0] PFN_PID_FB = 2'h1;
    localparam logic [1:0] PFN_PID_TGT = 2'h2;
    localparam logic [4:0] A2FN_ADD = 5'h00;
    localparam logic [4:0] A2FN_AUX = 5'h02;
    localparam logic [15:0] FS_MIN = 16'h03E8;
    localparam logic [15:0] FS_MAX = 16'h7D00;
    localparam logic [15:0] FS_RST = 16'h05A0;
    localparam logic [15:0] PCT_FULL = 16'h2710;
    localparam logic [4:0] DIV_LAST = 5'h1D;
    typedef struct packed {
        logic [4:0] a2fn;
        logic swap;
        logic [1:0] pfn;
        logic [2:0] src;
    } frs_cfg_t;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } frs_req_t;
endpackage : frs_pkg

// file: dv/frs_src_model.sv
// Far-side model: pulse train source and contact input terminals
`timescale 1ns/100ps
module frs_src_model (
    // Clock
    input wire logic mclk_i,
    // Commands from the bench
    input wire logic [7:0] period_i,
    input wire logic [3:0] steps_cmd_i,
    input wire logic jog_cmd_i,
    // Pins
    output logic [3:0] step_pins_o,
    output logic jog_pin_o,
    output logic pulse_pin_o
);
    logic [7:0] cnt_q;

    initial begin
        cnt_q = 8'h00;
        pulse_pin_o = 1'b0;
        step_pins_o = 4'h0;
        jog_pin_o = 1'b0;
    end

    // Contacts move off the clock grid, as real switches do
    // Delayed updates keep every command, even two in one time step
    always @(steps_cmd_i or jog_cmd_i) begin
        step_pins_o <= #130 steps_cmd_i;
        jog_pin_o <= #130 jog_cmd_i;
    end

    // Locked to the clock so a gate holds an exact edge count; idle low when off
    always @(posedge mclk_i) begin
        if (period_i == 8'h00) begin
            cnt_q <= 8'h00;
            pulse_pin_o <= 1'b0;
        end else begin
            cnt_q <= (cnt_q + 8'h01 >= period_i) ? 8'h00 : cnt_q + 8'h01;
            pulse_pin_o <= (cnt_q < (period_i >> 1));
        end
    end
endmodule : frs_src_model

// file: dv/frs_top_test.sv
// Self-checking testbench of the frequency reference selector
`timescale 1ns/100ps
module frs_top_test;
    import frs_pkg::*;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    frs_req_t req = '0;
    logic [31:0] rd_data_o;
    logic [15:0] pri = 16'h0000, sec = 16'h0000, opt = 16'h0000;
    logic [3:0] step_pins, steps_cmd = 4'h0;
    logic jog_pin, jog_cmd = 1'b0, pulse_pin;
    logic [7:0] period = 8'h00;
    logic [15:0] freq_ref_o, pid_feedback_o, pid_target_o;
    logic jog_active_o;
    int num_errors = 0, num_checks = 0;
    logic [31:0] exp_q[$], e;
    logic [7:0] adr_q[$], a;
    logic rd_flag = 1'b0;
    logic [15:0] step_v[16];
    logic [15:0] src_v[4];
    logic [15:0] jog_v;

    always #25 mclk_i = ~mclk_i;

    frs_top #(.GATE_CYCLES(4000)) uut (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .req_i(req), .rd_data_o(rd_data_o),
        .analog_in_primary_i(pri), .analog_in_secondary_i(sec), .option_ref_i(opt),
        .step_select_i(step_pins), .jog_select_input_i(jog_pin),
        .pulse_train_input_pin_i(pulse_pin), .freq_ref_o(freq_ref_o),
        .pid_feedback_o(pid_feedback_o), .pid_target_o(pid_target_o),
        .jog_active_o(jog_active_o)
    );

    frs_src_model model (
        .mclk_i(mclk_i), .period_i(period), .steps_cmd_i(steps_cmd), .jog_cmd_i(jog_cmd),
        .step_pins_o(step_pins), .jog_pin_o(jog_pin), .pulse_pin_o(pulse_pin)
    );

    task automatic close_out();
        $display("Checks %0d, mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string n, input logic [31:0] ex, input logic [31:0] g);
        num_checks++;
        if (g !== ex) begin
            num_errors++;
            $display("Error %s expected %h seen %h", n, ex, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] ad, input logic [31:0] d);
        @(posedge mclk_i);
        req <= '{wr: 1'b1, rd: 1'b0, addr: ad, wdata: d};
        @(posedge mclk_i);
        req <= '0;
    endtask : wr

    // Expected word is queued; the monitor compares it when the data stand
    task automatic rd(input logic [7:0] ad, input logic [31:0] ex);
        exp_q.push_back(ex);
        adr_q.push_back(ad);
        @(posedge mclk_i);
        req <= '{wr: 1'b0, rd: 1'b1, addr: ad, wdata: 32'h0000_0000};
        @(posedge mclk_i);
        req <= '0;
    endtask : rd

    // Pins need two sync stages plus the output register; margin for the model delay
    task automatic exp_ref(input logic [15:0] ex);
        repeat (6) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("freq_ref_o", {16'h0000, ex}, {16'h0000, freq_ref_o});
    endtask : exp_ref

    always @(posedge mclk_i) begin
        if (rd_flag) begin
            e = exp_q.pop_front();
            a = adr_q.pop_front();
            num_checks++;
            if (rd_data_o !== e) begin
                num_errors++;
                $display("Error reg %h expected %h seen %h", a, e, rd_data_o);
            end
        end
        rd_flag = req.rd;
    end

    initial begin
        repeat (40000) @(posedge mclk_i);
        num_errors++;
        close_out();
    end

    initial begin
        void'($urandom(32'h45e2c8a6));
        repeat (20) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_FSCALE, {16'h0000, FS_RST});
        wr(8'h3C, 32'h0000_1234);
        rd(8'h3C, 32'h0000_0000);
        pri <= 16'h0BB8;
        sec <= 16'h07D0;
        exp_ref(16'h1388);
        pri <= 16'h1F40;
        sec <= 16'h1388;
        exp_ref(16'h2710);
        rd(ADDR_REF_OUT, 32'h0000_2710);
        $display("Test analog add done");
        wr(ADDR_CTRL, 32'h0002_0001);
        exp_ref(16'h1F40);
        steps_cmd <= 4'h1;
        exp_ref(16'h1388);
        wr(ADDR_CTRL, 32'h0002_0101);
        exp_ref(16'h1F40);
        steps_cmd <= 4'h0;
        exp_ref(16'h1388);
        $display("Test master aux done");
        // Analog slot: default function adds both terminals, saturated at full scale
        src_v = '{16'h0457, 16'h2710, 16'h08AE, 16'h0D05};
        wr(ADDR_KEYPAD, {16'h0000, src_v[0]});
        wr(ADDR_SERIAL, {16'h0000, src_v[2]});
        opt <= src_v[3];
        wr(ADDR_CTRL, 32'h0000_0101);
        for (int s = 0; s < 4; s++) begin
            wr(ADDR_CTRL, 32'(s));
            exp_ref(src_v[s]);
        end
        wr(ADDR_CTRL, 32'h0000_0025);
        exp_ref(src_v[3]);
        rd(ADDR_CTRL, 32'h0000_0023);
        $display("Test sources done");
        wr(ADDR_CTRL, 32'h0000_0000);
        for (int k = 1; k < NUM_STEPS; k++) begin
            step_v[k] = 16'($urandom_range(10000));
            wr(8'(ADDR_STEP_BASE + 4 * k), {16'h0000, step_v[k]});
        end
        jog_v = 16'($urandom_range(10000));
        wr(ADDR_STEP_LAST, {16'h0000, jog_v});
        rd(8'(ADDR_STEP_BASE + 60), {16'h0000, step_v[15]});
        for (int k = 1; k < NUM_STEPS; k++) begin
            steps_cmd <= 4'(k);
            exp_ref(step_v[k]);
        end
        jog_cmd <= 1'b1;
        steps_cmd <= 4'($urandom_range(15));
        exp_ref(jog_v);
        chk("jog_active_o", 32'h1, {31'h0, jog_active_o});
        jog_cmd <= 1'b0;
        steps_cmd <= 4'h0;
        exp_ref(src_v[0]);
        $display("Test multi-step done");
        wr(ADDR_FSCALE, 32'h0000_03E7);
        wr(ADDR_FSCALE, 32'h0000_7D01);
        rd(ADDR_FSCALE, {16'h0000, FS_RST});
        wr(ADDR_FSCALE, {16'h0000, FS_MAX});
        rd(ADDR_FSCALE, {16'h0000, FS_MAX});
        wr(ADDR_FSCALE, {16'h0000, FS_MIN});
        wr(ADDR_CTRL, 32'h0000_0004);
        period <= 8'h05;
        // One partial gate, then a full one, then the divider
        repeat (8100) @(posedge mclk_i);
        exp_ref(16'h1F40);
        rd(ADDR_PULSE_HZ, 32'h0000_0320);
        wr(ADDR_FSCALE, 32'h0000_0640);
        repeat (4100) @(posedge mclk_i);
        exp_ref(16'h1388);
        period <= 8'h02;
        repeat (8100) @(posedge mclk_i);
        exp_ref(16'h2710);
        wr(ADDR_CTRL, 32'h0000_0014);
        exp_ref(16'h0000);
        chk("pid_feedback_o", 32'h2710, {16'h0, pid_feedback_o});
        chk("pid_target_o", 32'h0, {16'h0, pid_target_o});
        wr(ADDR_CTRL, 32'h0000_0024);
        repeat (4) @(posedge mclk_i);
        @(negedge mclk_i);
        chk("pid_target_o", 32'h2710, {16'h0, pid_target_o});
        chk("pid_feedback_o", 32'h0, {16'h0, pid_feedback_o});
        rd(ADDR_PULSE_PCT, 32'h0000_2710);
        $display("Test pulse train done");
        repeat (4) @(posedge mclk_i);
        // Mid-run reset must restore the defaults
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL, 32'h0000_0001);
        rd(ADDR_FSCALE, {16'h0000, FS_RST});
        exp_ref(16'h2710);
        $display("Test mid-run reset done");
        repeat (4) @(posedge mclk_i);
        close_out();
    end
endmodule : frs_top_test
